/* bench/boot_loader_checker.sv */
`timescale 1ns/1ps
module boot_loader_checker (
   input wire       clk_sys,
   input wire       arst_n,
   input wire       boot_from_eeprom_select,
   input wire       write_protect,
   input wire       writeback_trigger,
   input wire       sda_oe_n,
   input wire       scl_oe_n,
   input wire       boot_busy_reg,
   input wire       boot_done_reg,
   input wire       waiting_writeback_reg,
   input wire       writeback_req_reg,
   input wire [9:0] core_pc_reg,
   input wire       sample_tick_reg
);
   reg [10:0] gap_reg;
   reg        seen_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Cycles since the last sample tick
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gap_reg <= 11'h0;
         seen_reg <= 1'b0;
      end else if (sample_tick_reg) begin
         gap_reg <= 11'h1;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 11'h1;
      end
   end
   chk_tick_gap: assert property (sample_tick_reg && seen_reg |-> gap_reg == 11'h400)
      else $error("sample tick spacing wrong");
   chk_pc_step: assert property (core_pc_reg != 10'h0 |-> core_pc_reg == $past(core_pc_reg) + 10'h1)
      else $error("slot counter skipped");
   chk_wb_pulse: assert property (writeback_req_reg |=> !writeback_req_reg)
      else $error("writeback request longer than one cycle");
   chk_wb_after_boot: assert property (writeback_req_reg |-> boot_done_reg && !boot_busy_reg)
      else $error("writeback request outside boot mode");
   chk_wb_cause: assert property (writeback_req_reg |-> $past(writeback_trigger, 2) != $past(writeback_trigger, 6))
      else $error("writeback request without trigger edge");
   chk_wait_done: assert property (waiting_writeback_reg |-> boot_done_reg && !boot_busy_reg)
      else $error("waiting for writeback while still booting");
   chk_skip_quiet: assert property (!(boot_from_eeprom_select && write_protect) |-> scl_oe_n && sda_oe_n)
      else $error("bus driven with boot straps low");
   chk_sda_framing: assert property ($rose(scl_oe_n) |-> $stable(sda_oe_n))
      else $error("data changed as clock released");
endmodule
bind eeprom_boot_message_loader boot_loader_checker chk_i (
   .clk_sys(clk_sys), .arst_n(arst_n), .boot_from_eeprom_select(boot_from_eeprom_select),
   .write_protect(write_protect), .writeback_trigger(writeback_trigger), .sda_oe_n(sda_oe_n),
   .scl_oe_n(scl_oe_n), .boot_busy_reg(boot_busy_reg), .boot_done_reg(boot_done_reg),
   .waiting_writeback_reg(waiting_writeback_reg), .writeback_req_reg(writeback_req_reg),
   .core_pc_reg(core_pc_reg), .sample_tick_reg(sample_tick_reg));

/* bench/eeprom_model.sv */
`timescale 1ns/1ps
module eeprom_model (
   input  wire scl,
   input  wire sda,
   output reg  sda_pull_n
);
   reg [7:0] mem [0:255];
   reg [7:0] sh;
   reg [7:0] ptr;
   integer   bitn;
   integer   nbyte;
   reg       act;
   reg       recv;
   reg       sel;
   reg       done;
   initial begin
      sda_pull_n = 1'b1;
      act = 1'b0;
      ptr = 8'h00;
   end
   // Start condition opens a transfer
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = 0;
      nbyte = 0;
      recv = 1'b1;
      done = 1'b0;
      act = 1'b1;
   end
   // Stop condition ends it
   always @(posedge sda) if (scl === 1'b1) act = 1'b0;
   // Bits taken while clock high, MSB first; master nack ends a read
   always @(posedge scl) if (act) begin
      if (bitn == 8) begin
         if (!recv && sda) done = 1'b1;
         bitn = 0;
      end else begin
         sh = {sh[6:0], sda};
         bitn = bitn + 1;
      end
   end
   // Ack, pointer and read data change only while clock low
   always @(negedge scl) if (act) begin
      sda_pull_n = 1'b1;
      if (recv && bitn == 8) begin
         if (nbyte == 0) sel = (sh[7:1] == 7'h50);
         else if (sel) ptr = sh;
         sda_pull_n = !sel;
         recv = !(nbyte == 0 && sh[0]);
         nbyte = nbyte + 1;
      end else if (!recv && sel && !done && bitn < 8) begin
         sda_pull_n = mem[ptr][7 - bitn];
      end else if (!recv && bitn == 8) begin
         ptr = ptr + 8'h01;
      end
   end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   reg         clk_sys;
   reg         arst_n;
   reg         boot_sel;
   reg         wp;
   reg         wb_trig;
   wire        sda_oe_n;
   wire        scl_oe_n;
   wire        ee_pull_n;
   wire        sda;
   wire        busy, done, waiting, wb_req, muted, tick;
   wire [9:0]  pc;
   wire [39:0] instr;
   wire [31:0] prm;
   integer     fail_count, n_tests, cyc, wb_cnt, i;
   reg [31:0]  p0, p1;
   reg [39:0]  g;
   // Open-drain data line with pull-up
   assign sda = sda_oe_n & ee_pull_n;
   eeprom_boot_message_loader #(.QUARTER_CYCLES(4), .DELAY_UNIT_CYCLES(1)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .boot_from_eeprom_select(boot_sel),
      .write_protect(wp), .writeback_trigger(wb_trig), .sda_in(sda), .sda_oe_n(sda_oe_n),
      .scl_oe_n(scl_oe_n), .boot_busy_reg(busy), .boot_done_reg(done),
      .waiting_writeback_reg(waiting), .writeback_req_reg(wb_req), .outputs_muted_reg(muted),
      .core_pc_reg(pc), .core_instr_reg(instr), .core_param_reg(prm), .sample_tick_reg(tick));
   eeprom_model ee (.scl(scl_oe_n), .sda(sda), .sda_pull_n(ee_pull_n));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Write length counts device and address bytes
   function [15:0] wlen(input integer words, input integer bpw);
      wlen = 3 + words * bpw;
   endfunction
   task ld(input integer a, input [63:0] v, input integer n);
      for (i = 0; i < n; i++) ee.mem[a + i] = v[8 * (n - 1 - i) +: 8];
   endtask
   task chk(input string nm, input [39:0] got, input [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Reset with given straps, then wait for the boot to finish
   task do_boot(input s, input w);
      integer k;
      @(posedge clk_sys);
      arst_n <= 1'b0;
      boot_sel <= s;
      wp <= w;
      repeat (3) @(posedge clk_sys);
      wb_cnt = 0;
      arst_n <= 1'b1;
      k = 0;
      @(posedge clk_sys);
      while (busy !== 1'b0 && k < 30000) begin
         @(posedge clk_sys);
         k++;
      end
      #1;
   endtask
   // Wait for a slot, then let its words land
   task peek(input [9:0] idx);
      integer k;
      k = 0;
      while (pc !== idx && k < 3000) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      @(posedge clk_sys);
      #1;
   endtask
   task edge_wb(input v, input integer exp);
      @(posedge clk_sys);
      wb_trig <= v;
      repeat (20) @(posedge clk_sys);
      #1;
      chk("writeback count", wb_cnt, exp);
   endtask
   always @(posedge clk_sys) if (wb_req === 1'b1) wb_cnt = wb_cnt + 1;
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      wb_cnt = 0;
      arst_n = 1'b0;
      boot_sel = 1'b1;
      wp = 1'b1;
      wb_trig = 1'b0;
      i = $urandom(10);
      p0 = $urandom;
      p1 = $urandom;
      g = {8'($urandom), 32'($urandom)};
      for (i = 0; i < 256; i++) ee.mem[i] = 8'h00;
      // Interface enable plus unmute, params, program, delay, modes, end-wait, dead write
      ld(0, 64'h01_00_05_00_08_1c_00_48, 8);
      ld(8, {8'h01, wlen(2, 4), 24'h00_00_05}, 6);
      ld(14, {p0, p1}, 8);
      ld(22, {8'h01, wlen(1, 5), 24'h00_04_03}, 6);
      ld(28, g, 5);
      ld(33, 56'h02_00_10_03_04_05_06, 7);
      ld(40, 64'h01_00_05_00_08_1c_00_00, 8);
      do_boot(1'b1, 1'b1);
      chk("done", done, 40'h1);
      chk("waiting", waiting, 40'h1);
      chk("muted", muted, 40'h0);
      peek(10'h005);
      chk("param 5", prm, p0);
      peek(10'h006);
      chk("param 6", prm, p1);
      peek(10'h007);
      chk("param 7", prm, 40'h0);
      peek(10'h003);
      chk("program 3", instr, g);
      edge_wb(1'b1, 0);
      edge_wb(1'b0, 1);
      edge_wb(1'b1, 1);
      edge_wb(1'b0, 2);
      ld(0, 24'h03_00_06, 3);
      do_boot(1'b1, 1'b1);
      chk("done", done, 40'h1);
      chk("waiting", waiting, 40'h0);
      chk("muted", muted, 40'h1);
      peek(10'h005);
      chk("param 5", prm, 40'h0);
      edge_wb(1'b1, 1);
      edge_wb(1'b0, 1);
      edge_wb(1'b1, 1);
      do_boot(1'b1, 1'b0);
      chk("done", done, 40'h0);
      edge_wb(1'b0, 0);
      edge_wb(1'b1, 0);
      end_sim;
   end
endmodule

/* inc/boot_loader_consts.vh */
`ifndef BOOT_LOADER_CONSTS_VH
`define BOOT_LOADER_CONSTS_VH

// Message type codes
`define MSG_END          8'h00
`define MSG_WRITE        8'h01
`define MSG_DELAY        8'h02
`define MSG_NOP          8'h03
`define MSG_WB_MULTI     8'h04
`define MSG_WB_FALLING   8'h05
`define MSG_END_WAIT_WB  8'h06

// Serial memory bus addresses and start pointer
`define EE_ADDR_WR       8'ha0
`define EE_ADDR_RD       8'ha1
`define EE_START_BYTE    8'h00

// Target memory map
`define PARAM_BASE       16'h0000
`define PROG_BASE        16'h0400
`define REG_BASE         16'h0800
`define REG_END          16'h0840
`define PARAM_BYTES      3'h4
`define PROG_BYTES       3'h5
`define REG_BYTES        3'h2
`define MEM_DEPTH        11'h400
`define MEM_LAST         10'h3ff
`define REG_LAST         6'h3f
`define CORE_CTRL_IDX    6'h1c
`define CORE_UNMUTE_BIT  3
`define PASS_SLOTS       10'h004

// Header bytes of a write body: device, address high, address low
`define WR_HDR_LAST      2'h2

// Serial clock full period: 8 x 48 kHz gives about 2604 ns
`define SCL_PERIOD_NS    2604
`define CLK_PERIOD_NS    10

`endif

/* rtl/eeprom_boot_message_loader.v */
// How it works
// R1 - First byte of each message is its type; bytes MSB first; start at zero.
// R2 - Boot starts at reset release only with boot-select and write-protect high.
// R3 - 0x00 ends, 0x02 waits a two-byte delay, 0x03 does nothing.
// R4 - 0x01 writes: length, device byte, target address, consecutive data.
// R5 - Length counts all bytes after it, device and address bytes included.
// R6 - 0x04 allows repeated writebacks for the rest of operation.
// R7 - 0x05 makes the writeback trigger falling-edge sensitive.
// R8 - Trigger edge in boot mode starts writeback; only one unless repeats allowed.
// R9 - 0x06 ends the sequence and waits for a writeback trigger.
// R10 - The image should first enable interface register writes in core control.
// R11 - Parameter memory: 1024 x 32 at 0x0000 to 0x03ff, writable.
// R12 - Program memory: 1024 x 40 at 0x0400 to 0x07ff, direct write.
// R13 - Writers should clear internal registers before direct memory writes.
// R14 - Both memories load from on-chip boot contents before any message.
// R15 - Parameter and register memories reset to zero; program memory is given the default program.
// R16 - Default program passes inputs to outputs, with outputs muted.
// R17 - Core steps through all 1024 program slots every sample period.
// R18 - Boot reads the serial memory at bus address 0xa1 as master.
`timescale 1ns/1ps
`include "boot_loader_consts.vh"

module eeprom_boot_message_loader #(
   parameter QUARTER_CYCLES    = `SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS),
   parameter DELAY_UNIT_CYCLES = 1
) (
   input  wire        clk_sys,
   input  wire        arst_n,
   input  wire        boot_from_eeprom_select,
   input  wire        write_protect,
   input  wire        writeback_trigger,
   input  wire        sda_in,
   output wire        sda_oe_n,
   output wire        scl_oe_n,
   output reg         boot_busy_reg,
   output reg         boot_done_reg,
   output reg         waiting_writeback_reg,
   output reg         writeback_req_reg,
   output reg         outputs_muted_reg,
   output reg  [9:0]  core_pc_reg,
   output reg  [39:0] core_instr_reg,
   output reg  [31:0] core_param_reg,
   output reg         sample_tick_reg
);
   localparam [10:0] S_INIT = 11'h001, S_CHK = 11'h002, S_TYPE = 11'h004, S_LEN1 = 11'h008,
                     S_LEN2 = 11'h010, S_DLY1 = 11'h020, S_DLY2 = 11'h040, S_DWAIT = 11'h080,
                     S_BODY = 11'h100, S_IDLE = 11'h200, S_WAITWB = 11'h400;

   reg  [31:0] param_ram [0:1023];
   reg  [39:0] prog_ram  [0:1023];
   reg  [15:0] reg_ram   [0:63];

   reg  [10:0] st_reg;
   reg  [10:0] init_idx_reg;
   reg         pend_reg;
   reg         req_reg;
   reg         stop_reg;
   reg  [15:0] len_reg;
   reg  [15:0] addr_reg;
   reg  [1:0]  hdr_reg;
   reg  [2:0]  nbyte_reg;
   reg  [39:0] acc_reg;
   reg  [15:0] dly_reg;
   reg  [15:0] unit_reg;
   reg         wb_multi_reg;
   reg         wb_falling_reg;
   reg         wb_used_reg;
   reg         boot_mode_reg;
   reg         we_reg;
   reg  [15:0] we_addr_reg;
   reg  [39:0] we_data_reg;
   reg         init_we_reg;
   reg  [9:0]  init_addr_reg;
   reg  [2:0]  strap_s1_reg;
   reg  [2:0]  strap_s2_reg;
   reg         wb_prev_reg;

   wire [7:0]  rd_data;
   wire        rd_valid;
   wire        rd_busy;
   wire        got = pend_reg && rd_valid;
   wire        wb_edge = wb_falling_reg ? (wb_prev_reg && !strap_s2_reg[2])
                                        : (!wb_prev_reg && strap_s2_reg[2]);

   // Bytes per word of the target region
   function [2:0] word_bytes;
      input [15:0] a;
      begin
         if (a < `PROG_BASE)
            word_bytes = `PARAM_BYTES;
         else if (a < `REG_BASE)
            word_bytes = `PROG_BYTES;
         else
            word_bytes = `REG_BYTES;
      end
   endfunction

   // Boot contents of program memory: pass-through slots, the rest idle
   function [39:0] default_prog;
      input [9:0] a;
      begin
         default_prog = (a < `PASS_SLOTS) ? {30'h0000_0000, a} : 40'h00_0000_0000;
      end
   endfunction

   eeprom_byte_reader #(
      .QUARTER_CYCLES (QUARTER_CYCLES)
   ) u_reader (
      .clk_sys        (clk_sys),
      .arst_n         (arst_n),
      .byte_req       (req_reg),
      .read_stop      (stop_reg),
      .byte_data_reg  (rd_data),
      .byte_valid_reg (rd_valid),
      .busy_reg       (rd_busy),
      .sda_in         (sda_in),
      .sda_oe_n_reg   (sda_oe_n),
      .scl_oe_n_reg   (scl_oe_n)
   );

   // Strap and trigger synchronisers
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         strap_s1_reg <= 3'h0;
         strap_s2_reg <= 3'h0;
         wb_prev_reg  <= 1'b0;
      end else begin
         strap_s1_reg <= {writeback_trigger, write_protect, boot_from_eeprom_select};
         strap_s2_reg <= strap_s1_reg;
         wb_prev_reg  <= strap_s2_reg[2];
      end
   end

   // Memory write port, shared by boot load and write messages
   always @(posedge clk_sys) begin
      if (init_we_reg) begin
         param_ram[init_addr_reg] <= 32'h0000_0000;               // R15
         prog_ram[init_addr_reg]  <= default_prog(init_addr_reg); // R14 R16
         reg_ram[init_addr_reg[5:0]] <= 16'h0000;                 // R15
      end else if (we_reg) begin
         if (we_addr_reg < `PROG_BASE)
            param_ram[we_addr_reg[9:0]] <= we_data_reg[31:0];     // R11
         else if (we_addr_reg < `REG_BASE)
            prog_ram[we_addr_reg[9:0]] <= we_data_reg;            // R12
         else if (we_addr_reg < `REG_END)
            reg_ram[we_addr_reg[5:0]] <= we_data_reg[15:0];
      end
   end

   // Core fetch: every slot each sample period
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         core_pc_reg     <= 10'h000;
         core_instr_reg  <= 40'h00_0000_0000;
         core_param_reg  <= 32'h0000_0000;
         sample_tick_reg <= 1'b0;
      end else if (st_reg != S_INIT) begin
         core_pc_reg     <= core_pc_reg + 10'h001;                // R17
         core_instr_reg  <= prog_ram[core_pc_reg];
         core_param_reg  <= param_ram[core_pc_reg];
         sample_tick_reg <= (core_pc_reg == `MEM_LAST);          // R17
      end else begin
         sample_tick_reg <= 1'b0;
      end
   end

   // Mute follows core control register
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         outputs_muted_reg <= 1'b1;                               // R16
      else if (st_reg != S_INIT)
         outputs_muted_reg <= !reg_ram[`CORE_CTRL_IDX][`CORE_UNMUTE_BIT];
   end

   // Writeback trigger detection
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         writeback_req_reg <= 1'b0;
         wb_used_reg       <= 1'b0;
      end else begin
         writeback_req_reg <= 1'b0;
         if (boot_mode_reg && (st_reg == S_IDLE || st_reg == S_WAITWB) && wb_edge
             && (wb_multi_reg || !wb_used_reg)) begin             // R8 R6 R7
            writeback_req_reg <= 1'b1;
            wb_used_reg       <= 1'b1;
         end
      end
   end

   // Message sequencer
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg                <= S_INIT;
         init_idx_reg          <= 11'h000;
         init_we_reg           <= 1'b0;
         init_addr_reg         <= 10'h000;
         pend_reg              <= 1'b0;
         req_reg               <= 1'b0;
         stop_reg              <= 1'b0;
         len_reg               <= 16'h0000;
         addr_reg              <= 16'h0000;
         hdr_reg               <= 2'h0;
         nbyte_reg             <= 3'h0;
         acc_reg               <= 40'h00_0000_0000;
         dly_reg               <= 16'h0000;
         unit_reg              <= 16'h0000;
         wb_multi_reg          <= 1'b0;
         wb_falling_reg        <= 1'b0;
         boot_mode_reg         <= 1'b0;
         we_reg                <= 1'b0;
         we_addr_reg           <= 16'h0000;
         we_data_reg           <= 40'h00_0000_0000;
         boot_busy_reg         <= 1'b1;
         boot_done_reg         <= 1'b0;
         waiting_writeback_reg <= 1'b0;
      end else begin
         req_reg     <= 1'b0;
         stop_reg    <= 1'b0;
         we_reg      <= 1'b0;
         init_we_reg <= 1'b0;
         // One byte request outstanding at a time
         if ((st_reg == S_TYPE || st_reg == S_LEN1 || st_reg == S_LEN2 ||
              st_reg == S_DLY1 || st_reg == S_DLY2 || st_reg == S_BODY) && !pend_reg) begin
            req_reg  <= 1'b1;
            pend_reg <= 1'b1;
         end
         if (got)
            pend_reg <= 1'b0;
         case (st_reg)
            S_INIT: begin
               init_we_reg   <= 1'b1;
               init_addr_reg <= init_idx_reg[9:0];
               init_idx_reg  <= init_idx_reg + 11'h001;
               if (init_idx_reg == `MEM_DEPTH)
                  st_reg <= S_CHK;                                // R14
            end
            S_CHK: begin
               boot_mode_reg <= strap_s2_reg[0] && strap_s2_reg[1];
               if (strap_s2_reg[0] && strap_s2_reg[1]) begin
                  st_reg <= S_TYPE;                               // R2 R1
               end else begin
                  st_reg        <= S_IDLE;
                  boot_busy_reg <= 1'b0;
               end
            end
            S_TYPE: if (got) begin
               case (rd_data)
                  `MSG_WRITE: st_reg <= S_LEN1;                    // R4
                  `MSG_DELAY: st_reg <= S_DLY1;                    // R3
                  `MSG_NOP: st_reg <= S_TYPE;                      // R3
                  `MSG_WB_MULTI: wb_multi_reg <= 1'b1;             // R6
                  `MSG_WB_FALLING: wb_falling_reg <= 1'b1;         // R7
                  `MSG_END_WAIT_WB: begin
                     stop_reg              <= 1'b1;
                     st_reg                <= S_WAITWB;           // R9
                     waiting_writeback_reg <= 1'b1;
                     boot_busy_reg         <= 1'b0;
                     boot_done_reg         <= 1'b1;
                  end
                  default: begin
                     stop_reg      <= 1'b1;
                     st_reg        <= S_IDLE;                     // R3
                     boot_busy_reg <= 1'b0;
                     boot_done_reg <= 1'b1;
                  end
               endcase
            end
            S_LEN1: if (got) begin
               len_reg[15:8] <= rd_data;
               st_reg        <= S_LEN2;
            end
            S_LEN2: if (got) begin
               len_reg   <= {len_reg[15:8], rd_data};
               hdr_reg   <= 2'h0;
               nbyte_reg <= 3'h0;
               st_reg    <= ({len_reg[15:8], rd_data} == 16'h0000) ? S_TYPE : S_BODY;
            end
            // Device byte, target address, then packed words
            S_BODY: if (got) begin
               len_reg <= len_reg - 16'h0001;                     // R5
               if (hdr_reg != 2'h3) begin
                  hdr_reg <= hdr_reg + 2'h1;
                  if (hdr_reg == 2'h1)
                     addr_reg[15:8] <= rd_data;
                  if (hdr_reg == `WR_HDR_LAST) begin
                     addr_reg[7:0] <= rd_data;
                     hdr_reg       <= 2'h3;
                  end
               end else begin
                  acc_reg   <= {acc_reg[31:0], rd_data};
                  nbyte_reg <= nbyte_reg + 3'h1;
                  if (nbyte_reg + 3'h1 == word_bytes(addr_reg)) begin
                     we_reg      <= 1'b1;                          // R4
                     we_addr_reg <= addr_reg;
                     we_data_reg <= {acc_reg[31:0], rd_data};
                     addr_reg    <= addr_reg + 16'h0001;
                     nbyte_reg   <= 3'h0;
                  end
               end
               if (len_reg == 16'h0001)
                  st_reg <= S_TYPE;                               // R5
            end
            S_DLY1: if (got) begin
               dly_reg[15:8] <= rd_data;
               st_reg        <= S_DLY2;
            end
            S_DLY2: if (got) begin
               dly_reg  <= {dly_reg[15:8], rd_data};
               unit_reg <= 16'h0000;
               st_reg   <= S_DWAIT;
            end
            S_DWAIT: begin
               if (dly_reg == 16'h0000) begin
                  st_reg <= S_TYPE;                               // R3
               end else if (unit_reg == DELAY_UNIT_CYCLES - 1) begin
                  unit_reg <= 16'h0000;
                  dly_reg  <= dly_reg - 16'h0001;
               end else begin
                  unit_reg <= unit_reg + 16'h0001;
               end
            end
            S_IDLE: ;
            S_WAITWB: ;
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule

/* rtl/eeprom_byte_reader.v */
`timescale 1ns/1ps
`include "boot_loader_consts.vh"

module eeprom_byte_reader #(
   parameter QUARTER_CYCLES = `SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS)
) (
   input  wire       clk_sys,
   input  wire       arst_n,
   input  wire       byte_req,
   input  wire       read_stop,
   output reg  [7:0] byte_data_reg,
   output reg        byte_valid_reg,
   output reg        busy_reg,
   input  wire       sda_in,
   output reg        sda_oe_n_reg,
   output reg        scl_oe_n_reg
);
   localparam [6:0] S_IDLE = 7'h01, S_START = 7'h02, S_TX = 7'h04, S_RX = 7'h08,
                    S_HOLD = 7'h10, S_ACK = 7'h20, S_STOP = 7'h40;

   reg  [6:0]  st_reg;
   reg  [15:0] qcnt_reg;
   reg  [1:0]  phase_reg;
   reg  [3:0]  bit_reg;
   reg  [1:0]  idx_reg;
   reg  [7:0]  sh_reg;
   reg         nack_reg;
   reg         sda_s1_reg;
   reg         sda_s2_reg;
   wire        tick = (qcnt_reg == QUARTER_CYCLES - 1);

   // Data line synchroniser
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   // Quarter-bit timing and bus sequencing
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg         <= S_IDLE;
         qcnt_reg       <= 16'h0000;
         phase_reg      <= 2'h0;
         bit_reg        <= 4'h0;
         idx_reg        <= 2'h0;
         sh_reg         <= 8'h00;
         nack_reg       <= 1'b0;
         byte_data_reg  <= 8'h00;
         byte_valid_reg <= 1'b0;
         busy_reg       <= 1'b0;
         sda_oe_n_reg   <= 1'b1;
         scl_oe_n_reg   <= 1'b1;
      end else begin
         byte_valid_reg <= 1'b0;
         if (st_reg == S_IDLE || st_reg == S_HOLD || tick)
            qcnt_reg <= 16'h0000;
         else
            qcnt_reg <= qcnt_reg + 16'h0001;
         if (tick)
            phase_reg <= phase_reg + 2'h1;
         case (st_reg)
            S_IDLE: begin
               if (byte_req) begin
                  st_reg    <= S_START;
                  busy_reg  <= 1'b1;
                  idx_reg   <= 2'h0;
                  phase_reg <= 2'h0;
                  sh_reg    <= `EE_ADDR_WR;
               end
            end
            S_START: if (tick) begin
               case (phase_reg)
                  2'h0: begin
                     sda_oe_n_reg <= 1'b1;
                     scl_oe_n_reg <= 1'b1;
                  end
                  2'h1: sda_oe_n_reg <= 1'b0;
                  2'h2: scl_oe_n_reg <= 1'b0;
                  default: begin
                     st_reg  <= S_TX;
                     bit_reg <= 4'h0;
                  end
               endcase
            end
            // Eight address bits MSB first, then a released ack slot
            S_TX: if (tick) begin
               case (phase_reg)
                  2'h0: sda_oe_n_reg <= (bit_reg == 4'h8) ? 1'b1 : sh_reg[7];
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: ;
                  default: begin
                     scl_oe_n_reg <= 1'b0;
                     sh_reg       <= {sh_reg[6:0], 1'b0};
                     bit_reg      <= bit_reg + 4'h1;
                     if (bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        idx_reg <= idx_reg + 2'h1;
                        case (idx_reg)
                           2'h0, 2'h1: sh_reg <= `EE_START_BYTE;
                           2'h2: begin
                              sh_reg <= `EE_ADDR_RD; // R18
                              st_reg <= S_START;
                           end
                           default: st_reg <= S_RX;
                        endcase
                     end
                  end
               endcase
            end
            S_RX: if (tick) begin
               case (phase_reg)
                  2'h0: sda_oe_n_reg <= 1'b1;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sh_reg <= {sh_reg[6:0], sda_s2_reg}; // R1
                  default: begin
                     scl_oe_n_reg <= 1'b0;
                     bit_reg      <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7) begin
                        st_reg         <= S_HOLD;
                        byte_data_reg  <= sh_reg;
                        byte_valid_reg <= 1'b1;
                     end
                  end
               endcase
            end
            // Clock held low until the loader wants more or quits
            S_HOLD: begin
               if (byte_req || read_stop) begin
                  st_reg    <= S_ACK;
                  nack_reg  <= read_stop;
                  phase_reg <= 2'h0;
               end
            end
            S_ACK: if (tick) begin
               case (phase_reg)
                  2'h0: sda_oe_n_reg <= nack_reg;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: ;
                  default: begin
                     scl_oe_n_reg <= 1'b0;
                     bit_reg      <= 4'h0;
                     st_reg       <= nack_reg ? S_STOP : S_RX;
                  end
               endcase
            end
            S_STOP: if (tick) begin
               case (phase_reg)
                  2'h0: sda_oe_n_reg <= 1'b0;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sda_oe_n_reg <= 1'b1;
                  default: begin
                     st_reg   <= S_IDLE;
                     busy_reg <= 1'b0;
                  end
               endcase
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule
